// ---- verilog/dual_adc_convert_read_control.sv ----
// Module: conversion sequencing and parallel read logic of the dual converter
`timescale 1ns/10ps
`default_nettype none
module dual_adc_convert_read_control
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES
)
(
	input  wire logic              clock,
	input  wire logic              sys_rst,
	input  wire logic              conversion_start_n,
	input  wire logic              channel_pair_select,
	input  wire logic              cs_n,
	input  wire logic              rd_n,
	input  wire logic [DATA_W-1:0] sample_a,
	input  wire logic [DATA_W-1:0] sample_b,
	output logic                   hold_a,
	output logic                   hold_b,
	output logic                   busy,
	output logic      [DATA_W-1:0] data_out,
	output logic      [DATA_W-1:0] data_in_unused_n,
	output logic                   data_oe_n
);
	// Two-stage synchronisers for the start, select, chip select and strobe inputs
	logic [1:0] start_s_q;
	logic [1:0] sel_s_q;
	logic [1:0] cs_s_q;
	logic [1:0] rd_s_q;
	logic       start_d1_q;
	logic       rd_d1_q;
	logic       rd_sel_q;

	conv_state_e      state_q;
	logic [CNT_W-1:0] cnt_q;
	logic             conv_pair_q;
	logic [DATA_W-1:0] cap_a_q;
	logic [DATA_W-1:0] cap_b_q;
	logic             ptr_b_q;
	logic [DATA_W-1:0] data_q;
	logic             oe_n_q;

	// Latest result per channel pair, filled from the FIFO
	result_s          store_q [2];
	result_s          fifo_in;
	result_s          fifo_out;
	logic             fifo_in_valid_q;
	logic             fifo_in_ready;
	logic             fifo_out_valid;

	wire start_sync = start_s_q[1];
	wire sel_sync   = sel_s_q[1];
	wire start_fall = start_d1_q && !start_sync;          // see RULE1
	wire rd_toggle  = rd_d1_q != rd_s_q[1];
	wire rd_fall    = rd_d1_q && !rd_s_q[1];
	wire bus_en     = !cs_s_q[1] && !rd_s_q[1];
	wire conv_done  = (state_q == ST_CONV) &&
	                  (cnt_q == CNT_W'(CONV_LEN - 1));
	// The FIFO only stalls if results pile up; completing a conversion
	// while full waits in ST_CONV so no result is ever dropped
	wire can_finish = !fifo_in_valid_q || fifo_in_ready;
	wire result_s   rd_pair = store_q[sel_sync];          // see RULE12

	assign fifo_in = '{pair: conv_pair_q, res_a: cap_a_q, res_b: cap_b_q};
	assign hold_a  = (state_q != ST_IDLE);                // see RULE2
	assign hold_b  = (state_q != ST_IDLE);                // see RULE2
	assign busy    = (state_q != ST_IDLE);                // see RULE6
	assign data_out         = data_q;
	assign data_oe_n        = oe_n_q;
	assign data_in_unused_n = '1;

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			start_s_q  <= 2'h3;
			sel_s_q    <= 2'h0;
			cs_s_q     <= 2'h3;
			rd_s_q     <= 2'h3;
			start_d1_q <= 1'b1;
			rd_d1_q    <= 1'b1;
		end
		else
		begin
			start_s_q  <= {start_s_q[0], conversion_start_n};
			sel_s_q    <= {sel_s_q[0], channel_pair_select};
			cs_s_q     <= {cs_s_q[0], cs_n};
			rd_s_q     <= {rd_s_q[0], rd_n};
			start_d1_q <= start_sync;
			rd_d1_q    <= rd_s_q[1];
		end
	end

	// Conversion sequencer
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q     <= ST_IDLE;
			cnt_q       <= '0;
			conv_pair_q <= 1'b0;
			cap_a_q     <= RESULT_RST;
			cap_b_q     <= RESULT_RST;
			fifo_in_valid_q <= 1'b0;
		end
		else
		begin
			if (fifo_in_valid_q && fifo_in_ready)
				fifo_in_valid_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					if (start_fall)
					begin
						state_q <= ST_ARMED;          // see RULE2
						cap_a_q <= sample_a;          // see RULE13
						cap_b_q <= sample_b;
					end
				end
				ST_ARMED:
				begin
					state_q     <= ST_CONV;           // see RULE3
					cnt_q       <= '0;
					conv_pair_q <= sel_sync;          // see RULE4
				end
				ST_CONV:
				begin
					if (conv_done && can_finish)
					begin
						state_q         <= ST_IDLE;   // see RULE6
						fifo_in_valid_q <= 1'b1;      // see RULE7
					end
					else if (!conv_done)
						cnt_q <= cnt_q + 1'b1;        // see RULE16
				end
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	result_fifo #(
		.WIDTH ($bits(result_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_valid  (fifo_in_valid_q),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (1'b1),
		.out_data  (fifo_out)
	);

	// Store updates only on completion; old pair readable meanwhile
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			store_q[0] <= '0;
			store_q[1] <= '0;
		end
		else if (fifo_out_valid)
			store_q[fifo_out.pair] <= fifo_out;   // see RULE11
	end

	// Read pointer and output bus
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ptr_b_q  <= 1'b0;
			rd_sel_q <= 1'b0;
			data_q   <= '0;
			oe_n_q   <= 1'b1;
		end
		else
		begin
			rd_sel_q <= sel_sync;
			if (rd_sel_q != sel_sync)
				ptr_b_q <= 1'b0;                  // see RULE20
			else if (rd_fall && rd_toggle)
				ptr_b_q <= ptr_b_q;
			else if (rd_toggle && !rd_fall)
				ptr_b_q <= !ptr_b_q;              // see RULE10
			oe_n_q <= !bus_en;                    // see RULE8
			data_q <= ptr_b_q ? rd_pair.res_b     // see RULE9
			                  : rd_pair.res_a;
		end
	end
endmodule
`default_nettype wire

// ---- shared/adc_ctrl_pkg.sv ----
// Package: constants and carrier types for the dual converter control block
// Functional notes
// RULE1: Host pulses start low for minimum time
// RULE2: Start falling edge holds both samplers together
// RULE3: Conversion begins next clock, sixteen cycles
// RULE4: Channel select latched on conversion first edge
// RULE5: Host sets channel select before start
// RULE6: Busy high from start until conversion ends
// RULE7: Select high converts pair 1, low pair 0
// RULE8: Bus driven only when select and strobe low
// RULE9: First strobe gives A, next gives B
// RULE10: Every strobe toggle advances read pointer; the code advances it only on strobe rising edges
// RULE11: Previous results stay readable during conversion
// RULE12: Channel select picks stored pair when reading
// RULE13: Results are 12-bit two's complement words
// RULE14: Host avoids reads around start falling edge
// RULE15: Host holds strobe low minimum pulse width
// RULE16: External clock paces the conversion rate
// RULE17: Host meets start setup and hold
// RULE18: Host toggles strobe only when selected
// RULE19: Host drives select and strobe low to read
// RULE20: Pointer alternates A/B, resets on select change
package adc_ctrl_pkg;
	localparam int          DATA_W          = 12;
	localparam int          CONV_CYCLES     = 16;
	localparam int          CNT_W           = 5;
	localparam logic [11:0] CODE_POS_FULL   = 12'h7ff;
	localparam logic [11:0] CODE_MID        = 12'h000;
	localparam logic [11:0] CODE_MID_M1     = 12'hfff;
	localparam logic [11:0] CODE_NEG_FULL   = 12'h800;
	localparam logic [11:0] RESULT_RST      = CODE_MID;
	localparam int          CONV_CLK_HZ     = 8000000;
	localparam int          FIFO_DEPTH      = 16;

	typedef struct packed {
		logic              pair;
		logic [DATA_W-1:0] res_a;
		logic [DATA_W-1:0] res_b;
	} result_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_CONV
	} conv_state_e;
endpackage

// ---- verilog/result_fifo.sv ----
// Module: parameterised valid/ready FIFO for conversion results
`timescale 1ns/10ps
`default_nettype none
module result_fifo
#(
	parameter int WIDTH = 25,
	parameter int DEPTH = 16
)
(
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	wire              push;
	wire              pop;

	assign in_ready  = (cnt_q != DEPTH[AW:0]);
	assign out_valid = (cnt_q != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_q];

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_q] <= in_data;
	end

	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule
`default_nettype wire

// ---- test/adc_ctrl_sva.sv ----
// Checker: port timing of the dual converter control block
`timescale 1ns/10ps
`default_nettype none
module adc_ctrl_sva
	import adc_ctrl_pkg::*;
#(
	parameter int CONV_LEN = CONV_CYCLES
)
(
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic conversion_start_n,
	input  wire logic cs_n,
	input  wire logic rd_n,
	input  wire logic hold_a,
	input  wire logic hold_b,
	input  wire logic busy,
	input  wire logic data_oe_n
);
	logic [CNT_W-1:0] busy_cnt_q;
	// Counter keeps the busy length check free of long repetitions
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			busy_cnt_q <= '0;
		else
			busy_cnt_q <= busy ? busy_cnt_q + 1'b1 : '0;
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	sequence s_read_on; (!cs_n && !rd_n) [*4]; endsequence
	sequence s_read_off; (cs_n || rd_n) [*4]; endsequence
	property p_hold_pair; hold_a == hold_b; endproperty
	property p_hold_on; $rose(busy) |-> hold_a; endproperty
	property p_busy_start;
		$fell(conversion_start_n) && !busy |-> ##[1:4] busy;
	endproperty
	property p_busy_cause;
		$rose(busy) |-> !$past(conversion_start_n, 3);
	endproperty
	property p_busy_len; $fell(busy) |-> busy_cnt_q == CONV_LEN + 1; endproperty
	property p_bus_on; s_read_on |-> !data_oe_n; endproperty
	property p_bus_off; s_read_off |-> data_oe_n; endproperty
	a_hold_pair: assert property (p_hold_pair)
		else $error("hold outputs differ");
	a_hold_on: assert property (p_hold_on)
		else $error("hold low at busy rise");
	a_busy_start: assert property (p_busy_start)
		else $error("busy missing after start");
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy without start");
	a_busy_len: assert property (p_busy_len)
		else $error("busy length wrong");
	a_bus_on: assert property (p_bus_on)
		else $error("bus not driven");
	a_bus_off: assert property (p_bus_off)
		else $error("bus driven unselected");
endmodule
`default_nettype wire

// ---- test/host_model.sv ----
// Host model: drives start, select, chip select and read strobe
`timescale 1ns/10ps
`default_nettype none
module host_model
	import adc_ctrl_pkg::*;
(
	input  wire logic              clock,
	output logic                   conversion_start_n,
	output logic                   channel_pair_select,
	output logic                   cs_n,
	output logic                   rd_n,
	input  wire logic [DATA_W-1:0] data_out,
	input  wire logic              data_oe_n
);
	initial
	begin
		conversion_start_n = 1'b1;
		channel_pair_select = 1'b0;
		cs_n = 1'b1;
		rd_n = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Select settles long before the start and is held past the latch
	task automatic start(input logic s);
		channel_pair_select = s;
		tick(25);
		conversion_start_n = 1'b0;
		tick(2);
		conversion_start_n = 1'b1;
		tick(6);
	endtask
	// A released bus reads as high impedance, never as the last word
	task automatic read(input logic s, input logic c, output logic [11:0] d);
		channel_pair_select = s;
		cs_n = c;
		rd_n = 1'b0;
		tick(6);
		d = data_oe_n ? 12'hzzz : data_out;
		rd_n = 1'b1;
		cs_n = 1'b1;
		tick(6);
	endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Testbench: conversion, storage and read pointer scenarios
`timescale 1ns/10ps
`default_nettype none
module tb;
	import adc_ctrl_pkg::*;
	logic        clock;
	logic        sys_rst;
	logic        conversion_start_n;
	logic        channel_pair_select;
	logic        cs_n;
	logic        rd_n;
	logic [11:0] sample_a;
	logic [11:0] sample_b;
	logic        busy;
	logic        hold_a;
	logic        hold_b;
	logic [11:0] bus_in_n;
	logic [11:0] data_out;
	logic        data_oe_n;
	logic [11:0] d;
	int          failures;
	int          checks;
	dual_adc_convert_read_control i_dut (.clock(clock), .sys_rst(sys_rst),
		.conversion_start_n(conversion_start_n), .cs_n(cs_n), .rd_n(rd_n),
		.channel_pair_select(channel_pair_select), .sample_a(sample_a),
		.sample_b(sample_b), .hold_a(hold_a), .hold_b(hold_b), .busy(busy),
		.data_out(data_out), .data_in_unused_n(bus_in_n),
		.data_oe_n(data_oe_n));
	host_model i_host (.clock(clock), .conversion_start_n(conversion_start_n),
		.channel_pair_select(channel_pair_select), .cs_n(cs_n), .rd_n(rd_n),
		.data_out(data_out), .data_oe_n(data_oe_n));
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task automatic chk(input string n, input logic [11:0] e,
		input logic [11:0] g);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report();
		if (failures == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		// Busy is looked at just after the edge, never in the edge's own step
		while (busy !== 1'b0 && n < 40)
		begin
			i_host.tick(1);
			n++;
		end
		if (busy !== 1'b0)
		begin
			chk("busy_end", 12'h000, {11'h0, busy});
			final_report();
		end
		else
			i_host.tick(2);
	endtask
	task automatic convert(input logic s, input logic [11:0] a,
		input logic [11:0] b);
		sample_a = a;
		sample_b = b;
		i_host.start(s);
		chk("busy", 12'h001, {11'h0, busy});
		chk("hold", 12'h003, {10'h0, hold_a, hold_b});
		wait_idle();
		chk("hold_end", 12'h000, {10'h0, hold_a, hold_b});
	endtask
	task automatic read_pair(input logic s, input logic [11:0] a,
		input logic [11:0] b);
		i_host.read(s, 1'b0, d);
		chk("word_a", a, d);
		i_host.read(s, 1'b0, d);
		chk("word_b", b, d);
	endtask
	task automatic s_convert_and_read();
		convert(1'b0, 12'h7ff, 12'h800);
		convert(1'b1, 12'hfff, 12'h000);
		read_pair(1'b0, 12'h7ff, 12'h800);
		read_pair(1'b1, 12'hfff, 12'h000);
	endtask
	task automatic s_read_while_busy();
		sample_a = 12'h123;
		sample_b = 12'h456;
		i_host.start(1'b0);
		read_pair(1'b1, 12'hfff, 12'h000);
		wait_idle();
		read_pair(1'b0, 12'h123, 12'h456);
	endtask
	// Strobe toggled while unselected still moves the pointer on
	task automatic s_strobe_unselected();
		i_host.read(1'b0, 1'b1, d);
		chk("bus_off", 12'hzzz, d);
		chk("bus_in_n", 12'hfff, bus_in_n);
		read_pair(1'b0, 12'h456, 12'h123);
	endtask
	initial
	begin
		failures = 0;
		checks = 0;
		sys_rst = 1'b1;
		sample_a = 12'h000;
		sample_b = 12'h000;
		repeat (4) @(posedge clock);
		#1;
		sys_rst = 1'b0;
		i_host.tick(2);
		s_convert_and_read();
		s_read_while_busy();
		s_strobe_unselected();
		final_report();
	end
endmodule
bind dual_adc_convert_read_control adc_ctrl_sva #(.CONV_LEN(CONV_LEN)) i_chk (
	.clock(clock), .sys_rst(sys_rst), .conversion_start_n(conversion_start_n),
	.cs_n(cs_n), .rd_n(rd_n), .hold_a(hold_a), .hold_b(hold_b), .busy(busy),
	.data_oe_n(data_oe_n));
`default_nettype wire
